/* File: hw/fspr_top.sv */
// Status and function register bank of a serial flash, fed by SPI pins
//
// How it works
// [R01] No latch: gated instructions rejected, nothing changes
// [R02] Latch-set instruction sets write latch flag
// [R03] Host sends latch-set before each gated instruction
// [R04] Volatile parameter writes ignore the write latch
// [R05] Latch-clear instruction clears write latch flag
// [R06] Gated operation completion clears write latch
// [R07] Program opcodes 02h, 32h, 38h, 62h gated
// [R08] Erase opcodes D7h,20h,52h,D8h,C7h,60h,64h gated
// [R09] Opcodes 01h, 42h, 65h gated
// [R10] Opcodes 85h and 15h gated
// [R11] Program or erase into protected block inhibited
// [R12] Codes 1-5 protect top 1..16 blocks
// [R13] Codes 6-9 all; codes A-E bottom blocks
// [R14] Whole erase only with protect level zero
// [R15] Lock set and protect pin low: ignore
// [R16] Status write allowed unlocked or pin high
// [R17] Quad select swaps pin roles to data lines
// [R18] Bit 0 moves reset to shared pin while quad select is clear
// [R19] Program suspend flag set and cleared
// [R20] Erase suspend flag set and cleared
// [R21] Info row lock bits refuse row programming
// [R22] One-time bits never return to zero
// [R23] Busy flag high during operation, low after
// [R24] Only latch instructions set write latch
// [R25] Read-only and reserved bits ignore writes
`timescale 1ns/1ps
module fspr_top
  import fspr_pkg::*;
#(
  parameter logic [7:0] LATCH_SET_OPC = 8'hA1,
  parameter logic [7:0] LATCH_CLEAR_OPC = 8'hA2,
  parameter logic [7:0] SUSPEND_OPC = 8'hA3,
  parameter logic [7:0] RESUME_OPC = 8'hA4,
  parameter logic [7:0] V_ERP_OPC = 8'hA5,
  parameter logic [15:0] OP_CYCLES = 16'h0040,
  parameter logic FUNC_B0_DEFAULT = 1'b0
)(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic wp_n_in,
  output logic [7:0] status_out,
  output logic [7:0] function_out,
  output logic [7:0] read_param_out,
  output logic [7:0] ext_read_param_out,
  output logic [7:0] nv_read_param_out,
  output logic [7:0] nv_ext_read_param_out,
  output logic busy_out,
  output logic cmd_reject_out,
  output logic op_start_out,
  output logic [7:0] op_code_out,
  output logic [23:0] op_addr_out,
  output logic wp_pin_en_out,
  output logic pause_pin_en_out,
  output logic quad_data_en_out,
  output logic ded_reset_en_out,
  output logic shared_reset_en_out
);

  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] pin_f;
  logic [NUM_PINS-1:0] pin_prev_r;
  logic [7:0] shift_r;
  logic [2:0] bit_cnt_r;
  logic [2:0] byte_cnt_r;
  logic [7:0] opc_r;
  logic [7:0] data_r;
  logic [23:0] addr_r;
  fspr_state_t state_r, state_nxt;
  fspr_op_t kind_r, kind_nxt;
  logic [15:0] cnt_r;
  logic write_latch_flag_r, write_latch_flag_nxt;
  logic busy_flag_r;
  logic [3:0] bp_r;
  logic quad_select_r;
  logic status_lock_r;
  logic rst_dis_r;
  logic program_suspended_flag_r;
  logic erase_suspended_flag_r;
  logic [3:0] irl_r;
  logic [7:0] rp_r, erp_r, nv_rp_r, nv_erp_r;
  logic reject_r, op_start_r;
  logic [7:0] op_code_r;
  logic [23:0] op_addr_r;
  logic wp_en_r, pause_en_r, quad_en_r, ded_rst_r, shr_rst_r;

  // Pin synchronisers: three stages, value moves when stages 2 and 3 agree
  assign pin_raw = {wp_n_in, si_in, cs_n_in, sck_in};
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++)
    begin : g_sync
      logic s1_r, s2_r, s3_r, f_r;
      always_ff @(posedge clk_sys_in or negedge reset_n_in)
      begin
        if (!reset_n_in)
        begin
          s1_r <= PIN_IDLE[gi];
          s2_r <= PIN_IDLE[gi];
          s3_r <= PIN_IDLE[gi];
          f_r <= PIN_IDLE[gi];
        end
        else
        begin
          s1_r <= pin_raw[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r)
            f_r <= s3_r;
        end
      end
      assign pin_f[gi] = f_r;
    end
  endgenerate

  // Edge detection on the filtered pins
  logic sck_rise, cs_fall, cs_rise, cs_low, wp_n, si_bit;
  logic [7:0] byte_new;
  logic byte_done;
  assign sck_rise = pin_f[PIN_SCK] & ~pin_prev_r[PIN_SCK];
  assign cs_fall = ~pin_f[PIN_CS] & pin_prev_r[PIN_CS];
  assign cs_rise = pin_f[PIN_CS] & ~pin_prev_r[PIN_CS];
  assign cs_low = ~pin_f[PIN_CS];
  assign wp_n = pin_f[PIN_WP];
  assign si_bit = pin_f[PIN_SI];
  assign byte_new = {shift_r[6:0], si_bit};
  assign byte_done = sck_rise & cs_low & (bit_cnt_r == 3'h7);

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      pin_prev_r <= PIN_IDLE;
    else
      pin_prev_r <= pin_f;
  end

  // Bit and byte counters; counting saturates past the address bytes
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      shift_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 3'h0;
    end
    else if (cs_fall)
    begin
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 3'h0;
    end
    else if (sck_rise && cs_low)
    begin
      shift_r <= byte_new;
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (byte_done && byte_cnt_r != BYTES_ADDR)
        byte_cnt_r <= byte_cnt_r + 3'h1;
    end
  end

  // Frame capture: opcode, then first data byte doubling as address MSB
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      opc_r <= 8'h00;
      data_r <= 8'h00;
      addr_r <= 24'h000000;
    end
    else if (byte_done)
    begin
      case (byte_cnt_r)
        3'h0: opc_r <= byte_new;
        3'h1:
        begin
          data_r <= byte_new;
          addr_r[23:16] <= byte_new;
        end
        3'h2: addr_r[15:8] <= byte_new;
        3'h3: addr_r[7:0] <= byte_new;
        default: ;
      endcase
    end
  end

  // Protect level decode to one block
  function automatic logic blk_protected(input logic [3:0] lvl,
                                         input logic [4:0] blk);
    logic hit;
    hit = 1'b0;
    case (lvl)
      // [R12] Top blocks protected
      4'h1: hit = (blk >= 5'h1F);
      4'h2: hit = (blk >= 5'h1E);
      4'h3: hit = (blk >= 5'h1C);
      4'h4: hit = (blk >= 5'h18);
      4'h5: hit = (blk >= 5'h10);
      // [R13] All, then bottom blocks
      4'h6, 4'h7, 4'h8, 4'h9: hit = 1'b1;
      4'hA: hit = (blk < 5'h10);
      4'hB: hit = (blk < 5'h08);
      4'hC: hit = (blk < 5'h04);
      4'hD: hit = (blk < 5'h02);
      4'hE: hit = (blk == 5'h00);
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Opcode decode
  logic exec, idle, is_prog, is_irp, is_erase, is_chip, is_info_row_erase_cmd;
  logic is_stat_wr, is_func_wr, is_nvrp, is_nverp, is_boot, gated;
  logic has_addr, has_data, blk_prot, ir_locked, stat_locked, allowed;
  logic accept, latch_set, latch_clear, vol_rp_wr, vol_erp_wr;
  logic suspend, resume, op_done, mem_op;
  assign exec = cs_rise & (bit_cnt_r == 3'h0) & (byte_cnt_r != 3'h0);
  assign idle = (state_r == FSPR_IDLE);
  // [R07] Program opcodes gated
  assign is_prog = (opc_r == OPC_PAGE_PROG) | (opc_r == OPC_QPROG_A) |
                   (opc_r == OPC_QPROG_B);
  assign is_irp = (opc_r == OPC_IR_PROG);
  // [R08] Erase opcodes gated
  assign is_erase = (opc_r == OPC_SECT_A) | (opc_r == OPC_SECT_B) |
                    (opc_r == OPC_BLK32) | (opc_r == OPC_BLK64);
  assign is_chip = (opc_r == OPC_CHIP_A) | (opc_r == OPC_CHIP_B);
  assign is_info_row_erase_cmd = (opc_r == OPC_IR_ERASE);
  // [R09] Register write opcodes gated
  assign is_stat_wr = (opc_r == OPC_STAT_WR);
  assign is_func_wr = (opc_r == OPC_FUNC_WR);
  assign is_nvrp = (opc_r == OPC_NV_RP_WR);
  // [R10] Extended and boot writes gated
  assign is_nverp = (opc_r == OPC_NV_ERP_WR);
  assign is_boot = (opc_r == OPC_BOOT_WR);
  assign gated = is_prog | is_irp | is_erase | is_chip | is_info_row_erase_cmd |
                 is_stat_wr | is_func_wr | is_nvrp | is_nverp | is_boot;
  assign mem_op = is_prog | is_irp | is_erase | is_chip | is_info_row_erase_cmd;
  assign has_addr = (byte_cnt_r == BYTES_ADDR);
  assign has_data = (byte_cnt_r >= BYTES_DATA);
  assign blk_prot = blk_protected(bp_r, addr_r[BLK_LSB+4:BLK_LSB]);
  assign ir_locked = irl_r[addr_r[IR_ROW_LSB+1:IR_ROW_LSB]];
  assign stat_locked = status_lock_r & ~wp_n;

  // Permission per instruction class
  // [R11] [R14] [R15] [R16] [R21] Protection checks
  assign allowed = write_latch_flag_r & (
      ((is_prog | is_erase) & has_addr & ~blk_prot) |
      (is_irp & has_addr & ~ir_locked) |
      (is_info_row_erase_cmd & has_addr) |
      (is_chip & (bp_r == 4'h0)) |
      (is_stat_wr & has_data & ~stat_locked) |
      ((is_func_wr | is_nvrp | is_nverp | is_boot) & has_data));
  // [R01] Only granted when latch is set and device idle
  assign accept = exec & idle & gated & allowed;
  assign latch_set = exec & (opc_r == LATCH_SET_OPC) &
                     (state_r != FSPR_BUSY);
  assign latch_clear = exec & (opc_r == LATCH_CLEAR_OPC) &
                       (state_r != FSPR_BUSY);
  // [R04] Volatile writes skip the latch check
  assign vol_rp_wr = exec & has_data & (state_r != FSPR_BUSY) &
                     ((opc_r == OPC_V_RP_A) | (opc_r == OPC_V_RP_B));
  assign vol_erp_wr = exec & has_data & (state_r != FSPR_BUSY) &
                      (opc_r == V_ERP_OPC);
  assign suspend = exec & (opc_r == SUSPEND_OPC) &
                   (state_r == FSPR_BUSY) &
                   ((kind_r == FSPR_OP_PROG) | (kind_r == FSPR_OP_ERASE));
  assign resume = exec & (opc_r == RESUME_OPC) & (state_r == FSPR_SUSP);
  assign op_done = (state_r == FSPR_BUSY) & ~suspend & (cnt_r == 16'h0000);

  // Operation sequencer; suspend keeps the remaining count
  always_comb
  begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    case (state_r)
      FSPR_IDLE:
        if (accept)
        begin
          state_nxt = FSPR_BUSY;
          if (is_prog | is_irp)
            kind_nxt = FSPR_OP_PROG;
          else if (mem_op)
            kind_nxt = FSPR_OP_ERASE;
          else
            kind_nxt = FSPR_OP_REG;
        end
      FSPR_BUSY:
        if (suspend)
          state_nxt = FSPR_SUSP;
        else if (op_done)
        begin
          state_nxt = FSPR_IDLE;
          kind_nxt = FSPR_OP_NONE;
        end
      FSPR_SUSP:
        if (resume)
          state_nxt = FSPR_BUSY;
      default:
      begin
        state_nxt = FSPR_IDLE;
        kind_nxt = FSPR_OP_NONE;
      end
    endcase
  end

  // [R23] Busy follows the sequencer
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_r <= FSPR_IDLE;
      kind_r <= FSPR_OP_NONE;
      cnt_r <= 16'h0000;
      busy_flag_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      busy_flag_r <= (state_nxt == FSPR_BUSY);
      if (accept)
        cnt_r <= OP_CYCLES - 16'h0001;
      else if (state_r == FSPR_BUSY && !suspend && cnt_r != 16'h0000)
        cnt_r <= cnt_r - 16'h0001;
    end
  end

  // [R02] [R05] [R06] [R24] Latch: set wins over any clear
  assign write_latch_flag_nxt = latch_set ? 1'b1 :
                                (latch_clear | op_done) ? 1'b0 :
                                write_latch_flag_r;

  // Suspend flags: one instruction per frame, so set and clear never meet
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      write_latch_flag_r <= 1'b0;
      program_suspended_flag_r <= 1'b0;
      erase_suspended_flag_r <= 1'b0;
    end
    else
    begin
      write_latch_flag_r <= write_latch_flag_nxt;
      // [R19] Program suspend flag
      if (suspend && kind_r == FSPR_OP_PROG)
        program_suspended_flag_r <= 1'b1;
      else if (resume && kind_r == FSPR_OP_PROG)
        program_suspended_flag_r <= 1'b0;
      // [R20] Erase suspend flag
      if (suspend && kind_r == FSPR_OP_ERASE)
        erase_suspended_flag_r <= 1'b1;
      else if (resume && kind_r == FSPR_OP_ERASE)
        erase_suspended_flag_r <= 1'b0;
    end
  end

  // Register contents; new values take effect as the write starts
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      bp_r <= BP_RST;
      quad_select_r <= 1'b0;
      status_lock_r <= 1'b0;
      rst_dis_r <= FUNC_B0_DEFAULT;
      irl_r <= 4'h0;
      rp_r <= RP_RST;
      erp_r <= RP_RST;
      nv_rp_r <= RP_RST;
      nv_erp_r <= RP_RST;
    end
    else
    begin
      if (accept && is_stat_wr)
      begin
        bp_r <= data_r[5:2];
        quad_select_r <= data_r[6];
        status_lock_r <= data_r[7];
      end
      // [R22] [R25] One-time bits only OR in; other bits masked
      if (accept && is_func_wr)
      begin
        rst_dis_r <= rst_dis_r | (data_r[0] & FN_OTP_MASK[0]);
        irl_r <= irl_r | (data_r[7:4] & FN_OTP_MASK[7:4]);
      end
      if (accept && is_nvrp)
        nv_rp_r <= data_r;
      if (accept && is_nverp)
        nv_erp_r <= data_r;
      if (vol_rp_wr)
        rp_r <= data_r;
      if (vol_erp_wr)
        erp_r <= data_r;
    end
  end

  // Array request and reject pulses, plus pin role selection
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      reject_r <= 1'b0;
      op_start_r <= 1'b0;
      op_code_r <= 8'h00;
      op_addr_r <= 24'h000000;
      wp_en_r <= 1'b1;
      pause_en_r <= 1'b1;
      quad_en_r <= 1'b0;
      ded_rst_r <= 1'b1;
      shr_rst_r <= 1'b0;
    end
    else
    begin
      reject_r <= exec & gated & ~accept;
      op_start_r <= accept & mem_op;
      if (accept && mem_op)
      begin
        op_code_r <= opc_r;
        op_addr_r <= addr_r;
      end
      // [R17] Quad select takes both pins as data lines
      wp_en_r <= ~quad_select_r;
      pause_en_r <= ~quad_select_r;
      quad_en_r <= quad_select_r;
      // [R18] Reset function moves to the shared pin while quad select is clear
      ded_rst_r <= ~rst_dis_r;
      shr_rst_r <= rst_dis_r & ~quad_select_r;
    end
  end

  // Outputs, all from flip-flops; bit 1 of function reads zero
  assign status_out = {status_lock_r, quad_select_r, bp_r,
                       write_latch_flag_r, busy_flag_r};
  assign function_out = {irl_r, erase_suspended_flag_r,
                         program_suspended_flag_r, 1'b0, rst_dis_r};
  assign read_param_out = rp_r;
  assign ext_read_param_out = erp_r;
  assign nv_read_param_out = nv_rp_r;
  assign nv_ext_read_param_out = nv_erp_r;
  assign busy_out = busy_flag_r;
  assign cmd_reject_out = reject_r;
  assign op_start_out = op_start_r;
  assign op_code_out = op_code_r;
  assign op_addr_out = op_addr_r;
  assign wp_pin_en_out = wp_en_r;
  assign pause_pin_en_out = pause_en_r;
  assign quad_data_en_out = quad_en_r;
  assign ded_reset_en_out = ded_rst_r;
  assign shared_reset_en_out = shr_rst_r;

  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_start;
    accept;
  endsequence
  sequence s_busy_two;
    busy_flag_r ##1 busy_flag_r;
  endsequence

  a_gate_no_latch: assert property ( // [R01]
    exec && idle && gated && !write_latch_flag_r |=>
      !op_start_r && state_r == FSPR_IDLE && cmd_reject_out)
    else $error("gated instruction ran without latch");
  a_latch_set: assert property ( // [R02]
    latch_set |=> write_latch_flag_r)
    else $error("latch set failed");
  a_vol_write: assert property ( // [R04]
    vol_rp_wr |=> rp_r == $past(data_r))
    else $error("volatile write not taken");
  a_latch_clear: assert property ( // [R05]
    latch_clear && !latch_set |=> !write_latch_flag_r)
    else $error("latch clear failed");
  a_done_clears: assert property ( // [R06]
    op_done |=> !write_latch_flag_r && !busy_flag_r)
    else $error("latch not cleared at completion");
  a_prot_inhibit: assert property ( // [R11]
    exec && (is_prog || is_erase) && blk_prot |=> !op_start_r)
    else $error("protected block was started");
  a_chip_level: assert property ( // [R14]
    exec && is_chip && bp_r != 4'h0 |=> !op_start_r)
    else $error("whole erase with protect level");
  a_stat_locked: assert property ( // [R15]
    exec && is_stat_wr && stat_locked |=> $stable(bp_r) &&
      $stable(quad_select_r) && $stable(status_lock_r))
    else $error("locked status changed");
  a_irl_refuse: assert property ( // [R21]
    exec && is_irp && ir_locked |=> !op_start_r)
    else $error("locked info row programmed");
  a_otp_sticky: assert property ( // [R22]
    ((~irl_r & $past(irl_r)) == 4'h0) && !(!rst_dis_r && $past(rst_dis_r)))
    else $error("one-time bit returned to zero");
  a_busy_run: assert property ( // [R23]
    s_start |=> s_busy_two)
    else $error("busy not raised for operation");
  a_program_suspended_flag_set: assert property ( // [R19]
    suspend && kind_r == FSPR_OP_PROG |=>
      program_suspended_flag_r && !busy_flag_r)
    else $error("program suspend flag not set");
  a_stat_keeps_wel: assert property ( // [R24]
    accept && is_stat_wr |=> write_latch_flag_r)
    else $error("status write changed latch");

endmodule // fspr_top

/* File: hw/fspr_pkg.sv */
// Package: opcodes, register fields, reset values and state types
package fspr_pkg;
  // Opcodes that need the write latch
  localparam logic [7:0] OPC_PAGE_PROG = 8'h02;
  localparam logic [7:0] OPC_QPROG_A = 8'h32;
  localparam logic [7:0] OPC_QPROG_B = 8'h38;
  localparam logic [7:0] OPC_IR_PROG = 8'h62;
  localparam logic [7:0] OPC_SECT_A = 8'hD7;
  localparam logic [7:0] OPC_SECT_B = 8'h20;
  localparam logic [7:0] OPC_BLK32 = 8'h52;
  localparam logic [7:0] OPC_BLK64 = 8'hD8;
  localparam logic [7:0] OPC_CHIP_A = 8'hC7;
  localparam logic [7:0] OPC_CHIP_B = 8'h60;
  localparam logic [7:0] OPC_IR_ERASE = 8'h64;
  localparam logic [7:0] OPC_STAT_WR = 8'h01;
  localparam logic [7:0] OPC_FUNC_WR = 8'h42;
  localparam logic [7:0] OPC_NV_RP_WR = 8'h65;
  localparam logic [7:0] OPC_NV_ERP_WR = 8'h85;
  localparam logic [7:0] OPC_BOOT_WR = 8'h15;
  // Volatile read parameter writes, no latch needed
  localparam logic [7:0] OPC_V_RP_A = 8'hC0;
  localparam logic [7:0] OPC_V_RP_B = 8'h63;
  // Function register mask and reset values
  localparam logic [7:0] FN_OTP_MASK = 8'hF1;
  localparam logic [7:0] RP_RST = 8'h00;
  localparam logic [3:0] BP_RST = 4'h0;
  // Frame layout
  localparam logic [2:0] BYTES_ADDR = 3'h4;
  localparam logic [2:0] BYTES_DATA = 3'h2;
  localparam int BLK_LSB = 16;
  localparam int IR_ROW_LSB = 8;
  // Pin vector positions and idle levels
  localparam int PIN_SCK = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_SI = 2;
  localparam int PIN_WP = 3;
  localparam int NUM_PINS = 4;
  localparam logic [3:0] PIN_IDLE = 4'hA;
  typedef enum logic [1:0] {FSPR_IDLE, FSPR_BUSY, FSPR_SUSP} fspr_state_t;
  typedef enum logic [1:0]
    {FSPR_OP_NONE, FSPR_OP_PROG, FSPR_OP_ERASE, FSPR_OP_REG} fspr_op_t;
endpackage

/* File: test/fspr_host_model.sv */
// Serial host model that frames flash instructions on the link pins
`timescale 1ns/1ps
module fspr_host_model (
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out
);
  // Clock stands low between frames, chip select idles high
  initial
  begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end
  // Whole bytes from the top of w, MSB first, mode 0, 125 ns period
  task automatic send(input logic [31:0] w, input int n);
    int i;
    cs_n_out = 1'b0;
    // Skew keeps link edges away from the system clock edges
    #2;
    for (i = 0; i < 8 * n; i++)
    begin
      si_out = w[31 - i];
      #62.5 sck_out = 1'b1;
      #62.5 sck_out = 1'b0;
    end
    // Released data line shows the inverse of its last bit
    si_out = ~si_out;
    #62.5 cs_n_out = 1'b1;
    // Chip select high well over five system cycles
    #100;
  endtask
endmodule // fspr_host_model

/* File: test/fspr_top_tb.sv */
// Self-checking bench for the flash status and function register bank
`timescale 1ns/1ps
module fspr_top_tb;
  import fspr_pkg::*;
  localparam logic [7:0] SET_OPC = 8'hA1;
  localparam logic [7:0] CLR_OPC = 8'hA2;
  localparam logic [7:0] SUS_OPC = 8'hA3;
  localparam logic [7:0] RES_OPC = 8'hA4;
  localparam logic [7:0] VERP_OPC = 8'hA5;
  logic clk_sys_in;
  logic reset_n_in;
  logic wp_n_in;
  logic sck_w;
  logic cs_n_w;
  logic si_w;
  logic [7:0] status_out;
  logic [7:0] function_out;
  logic [7:0] rp_out;
  logic [7:0] erp_out;
  logic busy_out;
  logic rej_out;
  logic start_out;
  logic [4:0] pins;
  logic [7:0] nv_rp_out;
  logic [7:0] nv_erp_out;
  logic [7:0] opc_out;
  logic [23:0] adr_out;
  int err_total = 0;
  int samples_checked = 0;
  int rej_cnt = 0;
  int start_cnt = 0;
  int cyc = 0;
  logic [7:0] gops [16] = '{OPC_PAGE_PROG, OPC_QPROG_A, OPC_QPROG_B,
    OPC_IR_PROG, OPC_SECT_A, OPC_SECT_B, OPC_BLK32, OPC_BLK64,
    OPC_CHIP_A, OPC_CHIP_B, OPC_IR_ERASE, OPC_STAT_WR, OPC_FUNC_WR,
    OPC_NV_RP_WR, OPC_NV_ERP_WR, OPC_BOOT_WR};
  // Operations lengthened so the suspend frame still lands in time
  fspr_top #(.LATCH_SET_OPC(SET_OPC), .LATCH_CLEAR_OPC(CLR_OPC),
    .SUSPEND_OPC(SUS_OPC), .RESUME_OPC(RES_OPC), .V_ERP_OPC(VERP_OPC),
    .OP_CYCLES(16'h00A0)) u_fspr_top (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .sck_in(sck_w),
    .cs_n_in(cs_n_w), .si_in(si_w), .wp_n_in(wp_n_in),
    .status_out(status_out), .function_out(function_out),
    .read_param_out(rp_out), .ext_read_param_out(erp_out),
    .nv_read_param_out(nv_rp_out), .nv_ext_read_param_out(nv_erp_out),
    .busy_out(busy_out), .cmd_reject_out(rej_out),
    .op_start_out(start_out), .op_code_out(opc_out), .op_addr_out(adr_out),
    .wp_pin_en_out(pins[4]), .pause_pin_en_out(pins[3]),
    .quad_data_en_out(pins[2]), .ded_reset_en_out(pins[1]),
    .shared_reset_en_out(pins[0]));
  fspr_host_model u_fspr_host_model (
    .sck_out(sck_w), .cs_n_out(cs_n_w), .si_out(si_w));
  // System clock, 10 ns period
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // One-cycle pulses are counted so no fixed wait can miss them
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    if (rej_out === 1'b1) rej_cnt <= rej_cnt + 1;
    if (start_out === 1'b1) start_cnt <= start_cnt + 1;
  end
  // Hang guard, the whole run needs about 91000 cycles
  always @(posedge clk_sys_in)
  begin
    if (cyc == 100000)
    begin
      err_total = err_total + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Frame, then time for the filtered execute and its update
  task automatic cmd(input logic [31:0] w, input int n);
    u_fspr_host_model.send(w, n);
    // Send already leaves chip select high for ten cycles
    repeat (2) @(negedge clk_sys_in);
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 400 && busy_out !== 1'b0; k++)
      @(negedge clk_sys_in);
    chk(busy_out, 1'b0);
  endtask
  // Latch first, then the gated frame; a refusal shows as one pulse
  task automatic gated(input logic [31:0] w, input int n, input bit ok);
    int r0;
    r0 = rej_cnt;
    cmd({SET_OPC, 24'h000000}, 1);
    cmd(w, n);
    chk(24'(rej_cnt - r0), ok ? 24'h000000 : 24'h000001);
    wait_idle();
  endtask
  task automatic stat_wr(input logic [7:0] d);
    gated({OPC_STAT_WR, d, 16'h0000}, 2, 1'b1);
  endtask
  // Expected protection of a 64 KB block for a protect-level code
  function automatic bit prot(input int c, input int b);
    if (c >= 1 && c <= 5) return b >= 32 - (1 << (c - 1));
    if (c >= 6 && c <= 9) return 1'b1;
    if (c >= 10 && c <= 14) return b < (1 << (14 - c));
    return 1'b0;
  endfunction
  task automatic t_reset();
    chk(status_out, 8'h00);
    chk(function_out, 8'h00);
    chk(pins, 5'h1A);
    $display("t_reset done");
  endtask
  // Every gated opcode refused with the latch clear
  task automatic t_no_latch();
    int i;
    for (i = 0; i < 16; i++)
      cmd({gops[i], 24'h000000}, 4);
    chk(24'(rej_cnt), 24'h000010);
    chk(24'(start_cnt), 24'h000000);
    chk(status_out, 8'h00);
    $display("t_no_latch done");
  endtask
  task automatic t_latch();
    cmd({SET_OPC, 24'h000000}, 1);
    chk(status_out, 8'h02);
    cmd({CLR_OPC, 24'h000000}, 1);
    chk(status_out, 8'h00);
    cmd({OPC_V_RP_A, 8'h5A, 16'h0000}, 2);
    chk(rp_out, 8'h5A);
    cmd({OPC_V_RP_B, 8'hC3, 16'h0000}, 2);
    chk(rp_out, 8'hC3);
    cmd({VERP_OPC, 8'h3C, 16'h0000}, 2);
    chk(erp_out, 8'h3C);
    $display("t_latch done");
  endtask
  // Status write keeps the latch while busy, loses it at completion
  task automatic t_walk();
    cmd({SET_OPC, 24'h000000}, 1);
    cmd({OPC_STAT_WR, 8'h17, 16'h0000}, 2);
    chk(status_out, 8'h17);
    wait_idle();
    chk(status_out, 8'h14);
    $display("t_walk done");
  endtask
  // All sixteen codes against blocks 0, 1, 15, 16, 30, 31 and whole erase
  task automatic t_protect();
    int c;
    int j;
    logic [4:0] blks [6] = '{5'h00, 5'h01, 5'h0F, 5'h10, 5'h1E, 5'h1F};
    for (c = 0; c < 16; c++)
    begin
      stat_wr({2'b00, 4'(c), 2'b00});
      for (j = 0; j < 6; j++)
        gated({OPC_PAGE_PROG, 3'b000, blks[j], 16'h0000}, 4,
          !prot(c, blks[j]));
      gated({OPC_CHIP_A, 24'h000000}, 4, c == 0);
    end
    $display("t_protect done");
  endtask
  task automatic t_lock();
    stat_wr(8'h80);
    chk(status_out, 8'h80);
    wp_n_in = 1'b0;
    gated({OPC_STAT_WR, 8'h00, 16'h0000}, 2, 1'b0);
    chk(status_out, 8'h82);
    wp_n_in = 1'b1;
    stat_wr(8'h40);
    chk(status_out, 8'h40);
    chk(pins, 5'h06);
    stat_wr(8'h00);
    $display("t_lock done");
  endtask
  // One-time bits and info row locks
  task automatic t_func();
    gated({OPC_FUNC_WR, 8'h5F, 16'h0000}, 2, 1'b1);
    chk(function_out, 8'h51);
    chk(pins[1:0], 2'b01);
    gated({OPC_FUNC_WR, 8'h00, 16'h0000}, 2, 1'b1);
    chk(function_out, 8'h51);
    gated({OPC_IR_PROG, 24'h000000}, 4, 1'b0);
    gated({OPC_IR_PROG, 24'h000100}, 4, 1'b1);
    chk(opc_out, OPC_IR_PROG);
    chk(adr_out, 24'h000100);
    $display("t_func done");
  endtask
  // Non-volatile parameter and boot writes run once the latch is set
  task automatic t_nvreg();
    gated({OPC_NV_RP_WR, 8'h96, 16'h0000}, 2, 1'b1);
    chk(nv_rp_out, 8'h96);
    gated({OPC_NV_ERP_WR, 8'h69, 16'h0000}, 2, 1'b1);
    chk(nv_erp_out, 8'h69);
    gated({OPC_BOOT_WR, 8'h5A, 16'h0000}, 2, 1'b1);
    chk(status_out, 8'h00);
    $display("t_nvreg done");
  endtask
  // Suspend and resume of a program, then of an erase
  task automatic t_susp();
    int k;
    for (k = 0; k < 2; k++)
    begin
      cmd({SET_OPC, 24'h000000}, 1);
      cmd({k ? OPC_BLK64 : OPC_PAGE_PROG, 24'h000000}, 4);
      cmd({SUS_OPC, 24'h000000}, 1);
      chk({busy_out, function_out[3:2]}, k ? 3'h2 : 3'h1);
      cmd({RES_OPC, 24'h000000}, 1);
      chk({busy_out, function_out[3:2]}, 3'h4);
      wait_idle();
    end
    $display("t_susp done");
  endtask
  initial
  begin
    reset_n_in = 1'b0;
    wp_n_in = 1'b1;
    repeat (20) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    repeat (8) @(negedge clk_sys_in);
    t_reset();
    t_no_latch();
    t_latch();
    t_walk();
    t_protect();
    t_lock();
    t_func();
    t_nvreg();
    t_susp();
    give_verdict();
  end
endmodule // fspr_top_tb
